/* File: rtl/wdt_regs.vh */
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// Wishbone byte addresses (word aligned)
`define ADDR_MODE_CONFIG   4'h0
`define ADDR_KICK          4'h4
`define ADDR_STATUS        4'h8
`define ADDR_CONTROL       4'hC

// Mode register layout and reset value
`define MODE_RESET         8'h67
`define MODE_FIXED_HI      3'h3
`define MODE_PERIOD_HI     2
`define MODE_PERIOD_LO     0
`define MODE_SRC_BIT       3
`define MODE_STOP_BIT      4

// Kick register codes
`define KICK_CODE          8'hAC
`define KICK_READ_VALUE    8'h9A

// Interval exponents
`define EXP_BASE_INTOSC    5'h0B
`define EXP_BASE_X1        5'h0D

// Counter width covers the longest interval, 2^20
`define CNT_W              21

// Status bits
`define ST_RUNNING         0
`define ST_WRITTEN         1
`define ST_PENDING         2
`define ST_STOPPED         3
`define ST_SRC_ACTIVE      4

// Control register bits (CPU-core side signals)
`define CTL_BIT_ACCESS     0

`endif

/* File: rtl/wdt_interval.v */
`timescale 1ns/1ps
`include "wdt_regs.vh"

// Expands a period select and clock source into a terminal-count mask
module wdt_interval (
    input  wire [2:0]          period_sel,
    input  wire                use_x1,
    output wire [`CNT_W-1:0]   last_count
);
    wire [4:0] base;
    wire [4:0] exp_sel;

    assign base    = use_x1 ? `EXP_BASE_X1 : `EXP_BASE_INTOSC;
    assign exp_sel = base + {2'h0, period_sel};

    genvar i;
    generate
        for (i = 0; i < `CNT_W; i = i + 1) begin : g_mask
            assign last_count[i] = (i < exp_sel);
        end
    endgenerate
endmodule

/* File: rtl/wdt_reset_pulse.v */
`timescale 1ns/1ps
`include "wdt_regs.vh"

// Stretches a reset request over one active counting clock tick
module wdt_reset_pulse (
    input  wire clk,
    input  wire arst_n,
    input  wire request,
    input  wire tick,
    output wire wdt_reset_req
);
    reg armed_ff;
    reg out_ff;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_ff <= 1'b0;
            out_ff   <= 1'b0;
        end else begin
            if (request)
                armed_ff <= 1'b1;
            else if (out_ff && tick)
                armed_ff <= 1'b0;
            out_ff <= armed_ff | request;
        end
    end

    assign wdt_reset_req = out_ff;
endmodule

/* File: rtl/watchdog_reset_timer.v */
// Overview of operation
// R1: Counter overflow while counting raises the reset request, in both option variants.
// R2: A second mode register write after reset release raises reset while running.
// R3: Kick write other than ACH, or single-bit kick access, raises reset while running.
// R4: After software stop, misuse never resets and counting stays halted.
// R5: Misuse while source clock is stopped is held and asserted when it resumes.
// R6: Writing ACH to the kick register clears the count and restarts from zero.
// R7: Any mode register write clears the counter immediately.
// R8: After reset, count on internal oscillator with period select all ones, 2^18.
// R9: Period select sits in mode bits 2..0, written as a full byte.
// R10: Software writes the mode register only with full 8-bit accesses.
// R11: Non-stoppable variant fixes the internal oscillator and ignores mode bits 3 and 4.
// R12: Non-stoppable variant keeps counting in STOP, so overflow still resets.
// R13: Stoppable variant uses bits 3, 4 to pick oscillator, X1, or stopped.
// R14: Software writes mode bits 7..5 as 0, 1, 1 only.
// R15: Stoppable variant pauses in HALT and STOP, keeps count, resumes without clearing.
// R16: CPU and watchdog on X1 at STOP: resume only after settling time elapses.
// R17: CPU on X1, watchdog on oscillator at STOP: resume right after STOP release.
// R18: CPU on oscillator, watchdog on X1: resume at settling end or CPU switch.
// R19: Mode register resets to 67H, reads freely, accepts one write per reset.
// R20: Reading the kick register always returns 9AH.
// R21: Interval is 2^(11+n) oscillator cycles or 2^(13+n) X1 cycles.
// R22: Reset request is a registered pulse lasting at least one counting clock tick.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "wdt_regs.vh"

module watchdog_reset_timer (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        stoppable_option,
    input  wire        internal_osc_tick,
    input  wire        x1_tick,
    input  wire        x1_running,
    input  wire        cpu_on_x1,
    input  wire        halt_mode,
    input  wire        stop_mode,
    input  wire        osc_settle_done,
    output wire        wdt_reset_req
);
    // Pause sequencing states: running, in STOP, settling after STOP
    localparam [1:0] ST_RUN    = 2'h0;
    localparam [1:0] ST_STOP   = 2'h1;
    localparam [1:0] ST_SETTLE = 2'h2;

    reg  [7:0]         mode_ff;
    reg                mode_written_ff;
    reg                sw_stopped_ff;
    reg  [`CNT_W-1:0]  count_ff;
    reg  [`CNT_W-1:0]  nxt_count;
    reg                pending_ff;
    reg                bit_access_ff;
    reg  [1:0]         pstate_ff;
    reg  [1:0]         nxt_pstate;
    reg                stop_src_x1_ff;
    reg                cpu_on_x1_at_stop_ff;

    wire               bus_req;
    wire               wr_en;
    wire               rd_en;
    wire               wr_mode;
    wire               wr_kick;
    wire               use_x1;
    wire               src_tick;
    wire               src_active;
    wire               counting;
    wire               misuse;
    wire               overflow;
    wire               fire;
    wire [`CNT_W-1:0]  last_count;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en   = bus_req & wb_we_i & wb_sel_i[0];
    assign rd_en   = bus_req & ~wb_we_i;
    assign wr_mode = wr_en & (wb_adr_i == `ADDR_MODE_CONFIG);
    assign wr_kick = wr_en & (wb_adr_i == `ADDR_KICK);

    // Non-stoppable variant always counts on the internal oscillator
    assign use_x1 = stoppable_option & ~mode_ff[`MODE_STOP_BIT] & mode_ff[`MODE_SRC_BIT]; // [R11] [R13]

    wdt_interval u_interval (
        .period_sel (mode_ff[`MODE_PERIOD_HI:`MODE_PERIOD_LO]),
        .use_x1     (use_x1),
        .last_count (last_count)
    ); // [R9] [R21]

    // Source clock present: clock running and not paused by standby or settling
    assign src_active = ~stoppable_option |                                             // [R12]
                        ((pstate_ff == ST_RUN) & ~halt_mode & ~stop_mode &             // [R15]
                         (~use_x1 | x1_running));
    assign src_tick   = use_x1 ? x1_tick : internal_osc_tick;
    assign counting   = ~sw_stopped_ff & src_active;

    // Misuse while running; software stop suppresses it entirely
    assign misuse = ~sw_stopped_ff &                                                     // [R4]
                    ((wr_mode & mode_written_ff) |                                      // [R2]
                     (wr_kick & (bit_access_ff | (wb_dat_i[7:0] != `KICK_CODE))));      // [R3]

    assign overflow = counting & src_tick & (count_ff == last_count);                   // [R1]
    assign fire     = overflow | (pending_ff & src_active) | (misuse & src_active);     // [R5]

    // STOP-release sequencing for the stoppable variant
    always @* begin
        nxt_pstate = pstate_ff;
        case (pstate_ff)
            ST_RUN: begin
                if (stop_mode)
                    nxt_pstate = ST_STOP;
            end
            ST_STOP: begin
                if (!stop_mode) begin
                    if (stop_src_x1_ff)
                        nxt_pstate = ST_SETTLE;                                         // [R16] [R18]
                    else
                        nxt_pstate = ST_RUN;                                            // [R17]
                end
            end
            ST_SETTLE: begin
                if (osc_settle_done || (!cpu_on_x1_at_stop_ff && cpu_on_x1))
                    nxt_pstate = ST_RUN;                                                // [R16] [R18]
            end
            default: nxt_pstate = ST_RUN;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pstate_ff            <= ST_RUN;
            stop_src_x1_ff       <= 1'b0;
            cpu_on_x1_at_stop_ff <= 1'b0;
        end else begin
            pstate_ff <= stoppable_option ? nxt_pstate : ST_RUN;
            if (pstate_ff == ST_RUN && stop_mode) begin
                stop_src_x1_ff       <= use_x1;
                cpu_on_x1_at_stop_ff <= cpu_on_x1;
            end
        end
    end

    // Counter
    always @* begin
        nxt_count = count_ff;
        if (wr_mode)
            nxt_count = {`CNT_W{1'b0}};                                                 // [R7]
        else if (wr_kick && !misuse && wb_dat_i[7:0] == `KICK_CODE)
            nxt_count = {`CNT_W{1'b0}};                                                 // [R6]
        else if (counting && src_tick) begin
            if (count_ff == last_count)
                nxt_count = {`CNT_W{1'b0}};
            else
                nxt_count = count_ff + {{(`CNT_W-1){1'b0}}, 1'b1};                      // [R15]
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff         <= `MODE_RESET;                                             // [R8] [R19]
            mode_written_ff <= 1'b0;
            sw_stopped_ff   <= 1'b0;
            count_ff        <= {`CNT_W{1'b0}};
            pending_ff      <= 1'b0;
            bit_access_ff   <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            if (wr_mode && !mode_written_ff) begin
                mode_written_ff <= 1'b1;                                                // [R19]
                mode_ff[7:5] <= `MODE_FIXED_HI;                                         // [R14]
                mode_ff[`MODE_PERIOD_HI:`MODE_PERIOD_LO] <= wb_dat_i[2:0];              // [R9]
                if (stoppable_option) begin
                    mode_ff[`MODE_STOP_BIT] <= wb_dat_i[`MODE_STOP_BIT];                // [R13]
                    mode_ff[`MODE_SRC_BIT]  <= wb_dat_i[`MODE_SRC_BIT];
                    sw_stopped_ff           <= wb_dat_i[`MODE_STOP_BIT];                // [R4]
                end
            end
            // Misuse with the source clock stopped waits for it to return
            if (misuse && !src_active)
                pending_ff <= 1'b1;                                                     // [R5]
            else if (src_active)
                pending_ff <= 1'b0;
            if (wr_en && wb_adr_i == `ADDR_CONTROL)
                bit_access_ff <= wb_dat_i[`CTL_BIT_ACCESS];
        end
    end

    wdt_reset_pulse u_pulse (
        .clk           (clk),
        .arst_n        (arst_n),
        .request       (fire),
        .tick          (src_tick),
        .wdt_reset_req (wdt_reset_req)
    ); // [R22]

    // Wishbone slave: one registered ack per request, the cycle after the strobe
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (rd_en) begin
                case (wb_adr_i)
                    `ADDR_MODE_CONFIG: wb_dat_o <= {24'h000000, mode_ff};
                    `ADDR_KICK:        wb_dat_o <= {24'h000000, `KICK_READ_VALUE};      // [R20]
                    `ADDR_STATUS:      wb_dat_o <= {27'h0000000, src_active, sw_stopped_ff,
                                                    pending_ff, mode_written_ff, counting};
                    `ADDR_CONTROL:     wb_dat_o <= {31'h00000000, bit_access_ff};
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

/* File: verif/wdt_clock_source.sv */
`timescale 1ns/1ps

// Oscillator runs every other cycle; X1 stands still while absent
module wdt_clock_source (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic x1_running,
    output wire logic internal_osc_tick,
    output wire logic x1_tick
);
    logic [1:0] div_ff;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            div_ff <= 2'h0;
        else
            div_ff <= div_ff + 2'h1;
    end

    assign internal_osc_tick = div_ff[0];
    assign x1_tick           = x1_running && div_ff == 2'h3;
endmodule

/* File: verif/watchdog_reset_timer_checker.sv */
`timescale 1ns/1ps
`include "wdt_regs.vh"

module watchdog_reset_timer_checker (
    input logic        clk,
    input logic        arst_n,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [3:0]  wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        stoppable_option,
    input logic        internal_osc_tick,
    input logic        x1_tick,
    input logic        x1_running,
    input logic        wdt_reset_req
);
    logic take, mode_wr, kick_wr, rd, wr_ff, stop_ff, x1_ff;
    assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd      = take && !wb_we_i;
    assign mode_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == `ADDR_MODE_CONFIG;
    assign kick_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == `ADDR_KICK;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ff   <= 1'b0;
            stop_ff <= 1'b0;
            x1_ff   <= 1'b0;
        end else if (mode_wr && !wr_ff) begin
            wr_ff   <= 1'b1;
            stop_ff <= stoppable_option && wb_dat_i[4];
            x1_ff   <= stoppable_option && wb_dat_i[4:3] == 2'b01;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_mode_reset;
        rd && wb_adr_i == `ADDR_MODE_CONFIG && !wr_ff |=> wb_dat_o == {24'h000000, `MODE_RESET};
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode reset value");
    property p_kick_read;
        rd && wb_adr_i == `ADDR_KICK |=> wb_ack_o && wb_dat_o == {24'h000000, `KICK_READ_VALUE};
    endproperty
    a_kick_read: assert property (p_kick_read) else $error("kick readback");
    property p_fixed_src;
        rd && wb_adr_i == `ADDR_MODE_CONFIG && wr_ff && !stoppable_option |=> wb_dat_o[7:3] == 5'b01100;
    endproperty
    a_fixed_src: assert property (p_fixed_src) else $error("source bits kept");
    property p_second_mode;
        mode_wr && wr_ff && !stoppable_option |-> ##[1:3] wdt_reset_req;
    endproperty
    a_second_mode: assert property (p_second_mode) else $error("no reset on rewrite");
    property p_bad_kick;
        kick_wr && wb_dat_i[7:0] != `KICK_CODE && !stoppable_option |-> ##[1:3] wdt_reset_req;
    endproperty
    a_bad_kick: assert property (p_bad_kick) else $error("no reset on bad kick");
    property p_quiet;
        stop_ff |-> !$rose(wdt_reset_req);
    endproperty
    a_quiet: assert property (p_quiet) else $error("reset while stopped");
    property p_pending;
        x1_ff && !x1_running |-> !$rose(wdt_reset_req);
    endproperty
    a_pending: assert property (p_pending) else $error("reset while source stopped");
    property p_hold;
        wdt_reset_req && !internal_osc_tick && !x1_tick && !$past(internal_osc_tick) && !$past(x1_tick)
            |=> wdt_reset_req;
    endproperty
    a_hold: assert property (p_hold) else $error("reset pulse too short");

    c_rewrite: cover property (mode_wr && wr_ff);
    c_reset: cover property ($rose(wdt_reset_req));
    c_stop_kick: cover property (stop_ff && kick_wr);
endmodule

/* File: verif/watchdog_reset_timer_bench.sv */
`timescale 1ns/1ps
`include "wdt_regs.vh"

module watchdog_reset_timer_bench;
    logic        clk, arst_n, cyc, stb, we, ack, stoppable, x1_run, halt, stopm, req, osc_t, x1_t, seen_ff;
    logic [3:0]  adr, sel;
    logic [31:0] dat_i, dat_o;
    logic [31:0] exp_q[$];
    logic        cpu_x1, settle;
    int          bad_count, samples_checked;

    watchdog_reset_timer uut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .stoppable_option(stoppable), .internal_osc_tick(osc_t), .x1_tick(x1_t), .x1_running(x1_run),
        .cpu_on_x1(cpu_x1), .halt_mode(halt), .stop_mode(stopm), .osc_settle_done(settle), .wdt_reset_req(req));
    wdt_clock_source far_side (.clk(clk), .arst_n(arst_n), .x1_running(x1_run), .internal_osc_tick(osc_t),
        .x1_tick(x1_t));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task compare_read(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: read %h not %h", $time, g, e);
        end
    endtask

    task compare_flag(input logic e);
        samples_checked++;
        if (seen_ff !== e) begin
            bad_count++;
            $display("wrong value at %0t: reset request %b not %b", $time, seen_ff, e);
        end
    endtask

    always @(posedge clk) begin
        if (arst_n !== 1'b1)
            seen_ff <= 1'b0;
        else if (req === 1'b1)
            seen_ff <= 1'b1;
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
            compare_read(exp_q.pop_front(), dat_o);
    end

    task wb_cycle(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        sel   <= 4'hF;
        adr   <= a;
        dat_i <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task wb_read(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb_cycle(a, 1'b0, 8'h00);
    endtask

    task stop_pulse;
        stopm <= 1'b1;
        @(posedge clk);
        stopm <= 1'b0;
    endtask

    task start(input logic s, input logic [7:0] mode);
        @(posedge clk);
        arst_n    <= 1'b0;
        stoppable <= s;
        x1_run    <= 1'b1;
        halt      <= 1'b0;
        stopm     <= 1'b0;
        cpu_x1    <= 1'b0;
        settle    <= 1'b1;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        if (mode != 8'h00)
            wb_cycle(`ADDR_MODE_CONFIG, 1'b1, mode);
    endtask

    task expect_req(input int cycles, input logic e);
        repeat (cycles) @(posedge clk);
        compare_flag(e);
    endtask

    // Second mode write, random wrong kick code, single-bit kick access
    task misuse(input int k);
        logic [7:0] d;
        d = 8'($urandom);
        if (d == `KICK_CODE)
            d = 8'h00;
        if (k == 0)
            wb_cycle(`ADDR_MODE_CONFIG, 1'b1, 8'h61);
        if (k == 1)
            wb_cycle(`ADDR_KICK, 1'b1, d);
        if (k == 2)
            wb_cycle(`ADDR_CONTROL, 1'b1, 8'h01);
        if (k == 2)
            wb_cycle(`ADDR_KICK, 1'b1, `KICK_CODE);
    endtask

    initial begin
        {cyc, stb, we, adr, sel, dat_i, stoppable, halt, stopm, cpu_x1} = '0;
        settle = 1'b1;
        sel    = 4'hF;
        x1_run = 1'b1;
        arst_n = 1'b0;
        void'($urandom(32'h6B3DA434));
        start(1'b0, 8'h00);
        wb_read(`ADDR_MODE_CONFIG, 32'h67);
        wb_read(`ADDR_KICK, 32'h9A);
        wb_read(`ADDR_STATUS, 32'h11);
        wb_read(4'h2, 32'h0);
        wb_cycle(`ADDR_MODE_CONFIG, 1'b1, 8'h78);
        wb_read(`ADDR_MODE_CONFIG, 32'h60);
        stopm <= 1'b1;
        repeat (2000) @(posedge clk);
        wb_cycle(`ADDR_KICK, 1'b1, `KICK_CODE);
        expect_req(4080, 1'b0);
        expect_req(40, 1'b1);
        for (int k = 0; k < 3; k++) begin
            start(1'b0, 8'h67);
            misuse(k);
            expect_req(10, 1'b1);
            start(1'b1, 8'h77);
            wb_read(`ADDR_MODE_CONFIG, 32'h77);
            misuse(k);
            expect_req(300, 1'b0);
        end
        start(1'b1, 8'h68);
        x1_run <= 1'b0;
        misuse(1);
        expect_req(50, 1'b0);
        x1_run <= 1'b1;
        expect_req(20, 1'b1);
        settle <= 1'b0;
        stop_pulse();
        wb_read(`ADDR_STATUS, 32'h02);
        cpu_x1 <= 1'b1;
        wb_read(`ADDR_STATUS, 32'h13);
        stop_pulse();
        wb_read(`ADDR_STATUS, 32'h02);
        settle <= 1'b1;
        wb_read(`ADDR_STATUS, 32'h13);
        start(1'b1, 8'h60);
        settle <= 1'b0;
        cpu_x1 <= 1'b1;
        stop_pulse();
        wb_read(`ADDR_STATUS, 32'h13);
        wb_cycle(`ADDR_KICK, 1'b1, `KICK_CODE);
        expect_req(2000, 1'b0);
        halt <= 1'b1;
        expect_req(3000, 1'b0);
        halt <= 1'b0;
        expect_req(2060, 1'b0);
        expect_req(60, 1'b1);
        print_verdict();
    end

    initial begin
        #(8 * 40000);
        bad_count++;
        print_verdict();
    end
endmodule

bind watchdog_reset_timer watchdog_reset_timer_checker checker_inst (.*);
